// File: testbench/host_model.sv
// host side: convert strobe, shift clock and serial capture
`timescale 1ns/10ps
module host_model
(
    input  wire logic serial_data_q,
    output logic      shift_clk,
    output logic      convert_strobe_n
);
    // idle: sampling, shift clock parked high
    initial
    begin
        shift_clk = 1'b1;
        convert_strobe_n = 1'b1;
    end
    // a few pulses with the strobe high, so reset reaches the link side
    task automatic tick();
        repeat (3)
        begin
            #12 shift_clk = 1'b0;
            #32 shift_clk = 1'b1;
            #20;
        end
    endtask
    // one frame; each bit taken at a fall, before the device moves on
    task automatic frame(input int n, output logic [12:0] w);
        w = 13'h0000;
        #3 convert_strobe_n = 1'b0; // kept off the system clock edge
        #70;
        repeat (n)
        begin
            shift_clk = 1'b0;
            w = {w[11:0], serial_data_q};
            #32 shift_clk = 1'b1;
            #32;
        end
        #50 convert_strobe_n = 1'b1;
        #300;
    endtask
endmodule // host_model

// File: testbench/seq_checker_sva.sv
// port assertions for the conversion sequencer
`timescale 1ns/10ps
module seq_checker
(
    input wire logic                                      clk_sys,
    input wire logic                                      rst,
    input wire logic                                      convert_strobe_n,
    input wire logic                                      sampling_q,
    input wire logic                                      serial_data_oe,
    input wire logic [12:0]                               capacitive_weighting_array_q,
    input wire sar_conversion_sequencer_pkg::result_word_t result_q,
    input wire logic                                      result_done_q
);
    // one domain; sync delay of the strobe is two to four cycles
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_done_pulse: assert property (result_done_q |=> !result_done_q) else $error("done too long");
    chk_done_valid: assert property (result_done_q |-> result_q.valid) else $error("done not valid");
    chk_result_hold: assert property ($changed(result_q) |-> result_done_q || $past(result_done_q))
        else $error("result moved");
    chk_conv_start: assert property ($fell(convert_strobe_n) |-> ##[2:4] !sampling_q) else $error("no start");
    chk_oe_on: assert property ($fell(convert_strobe_n) |-> ##[2:4] serial_data_oe) else $error("no drive");
    chk_sample_hold: assert property (convert_strobe_n [*6] |-> sampling_q) else $error("not sampling");
    chk_steps_idle: assert property (convert_strobe_n [*6] |=> $stable(capacitive_weighting_array_q))
        else $error("step while sampling");
    chk_valid_keep: assert property (result_q.valid |=> result_q.valid) else $error("valid lost");
endmodule // seq_checker

bind sar_conversion_sequencer seq_checker chk_i (.clk_sys(clk_sys), .rst(rst), .convert_strobe_n(convert_strobe_n),
    .sampling_q(sampling_q), .serial_data_oe(serial_data_oe), .result_done_q(result_done_q),
    .capacitive_weighting_array_q(capacitive_weighting_array_q), .result_q(result_q));

// File: testbench/testbench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module testbench;
    logic                                        clk_sys, rst, comparator_high, shift_clk, convert_strobe_n;
    logic                                        serial_data_q, serial_data_oe, word_valid_q, result_done_q;
    logic [12:0]                                 trial_q, target, word;
    sar_conversion_sequencer_pkg::result_word_t  result_q;
    int                                          bad_count, checks_done, cycles;
    // offset-binary target beside the two's complement code it gives
    logic [25:0] rows [6] = '{{13'h0000, 13'h1000}, {13'h1FFF, 13'h0FFF}, {13'h0800, 13'h1800},
        {13'h17FF, 13'h07FF}, {13'h1000, 13'h0000}, {13'h0FFF, 13'h1FFF}};

    sar_conversion_sequencer dut (.clk_sys(clk_sys), .rst(rst), .shift_clk(shift_clk),
        .convert_strobe_n(convert_strobe_n), .comparator_high(comparator_high),
        .capacitive_weighting_array_q(trial_q), .sampling_q(), .serial_data_q(serial_data_q),
        .serial_data_oe(serial_data_oe), .word_valid_q(word_valid_q), .result_q(result_q),
        .result_done_q(result_done_q));
    host_model host (.serial_data_q(serial_data_q), .shift_clk(shift_clk), .convert_strobe_n(convert_strobe_n));

    // system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // comparator stands in for the analog core; hang guard
    always @(posedge clk_sys)
    begin
        comparator_high <= (target >= trial_q);
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [12:0] got, input logic [12:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // reset, table of codes, then abort and a second reset
    initial
    begin
        {rst, target, comparator_high, bad_count, checks_done, cycles} = '1;
        {target, comparator_high, bad_count, checks_done, cycles} = '0;
        for (int r = 0; r < 2; r++)
        begin
            fork host.tick(); join_none
            repeat (16) @(posedge clk_sys);
            rst <= 1'b0;
            @(posedge clk_sys);
            check({12'h000, result_q.valid}, 13'h0000);
            check({12'h000, word_valid_q}, 13'h0000);
            if (r == 1)
                wrap_up();
            // link-side reset only clears on shift falls after release
            #42 host.tick();
            for (int i = 0; i < 6; i++)
            begin
                @(posedge clk_sys);
                target <= rows[i][25:13];
                host.frame(13, word);
                check(result_q.code, rows[i][12:0]);
                check({12'h000, word_valid_q}, (i > 0) ? 13'h0001 : 13'h0000);
                check({12'h000, serial_data_oe}, 13'h0000);
                if (i > 0)
                    check(word, rows[i-1][12:0]);
            end
            $display("code table done");
            @(posedge clk_sys);
            target <= 13'h0555;
            host.frame(5, word);
            host.tick();
            check(result_q.code, 13'h1FFF);
            host.frame(13, word);
            check(word, 13'h1FFF);
            check(result_q.code, 13'h1555);
            $display("abort test done");
            @(posedge clk_sys);
            rst <= 1'b1;
        end
    end
endmodule // testbench

// File: verilog/level_sync.sv
// two-flop synchroniser for a single level
`timescale 1ns/10ps
module level_sync
(
    input  wire logic clk,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge clk)
    begin
        meta_q   <= async_in;
        sync_out <= meta_q;
    end

endmodule // level_sync

// File: verilog/sar_conversion_sequencer.sv
// conversion sequencer: approximation steps, result coding and serial output
// Notes on behaviour
// - strobe falling edge ends sampling, starts conversion
// - one 13-bit approximation step per shift pulse
// - finished approximation loads 13-bit result word
// - result is two's complement, msb is sign
// - differential span: 1000..0 up to 0111..1
// - bipolar span 11000.. to 00111.., same coding
// - unipolar span 0 0000.. to 0 1111..
// - out-of-span inputs give valid codes, never clamped
// - one coding for all inputs, no mode
// - result appears one conversion later; first invalid
// - strobe high samples; strobe low starts output
// - result shifts msb first per shift-clock fall
`timescale 1ns/10ps
`include "sar_conversion_sequencer_consts.svh"
module sar_conversion_sequencer
(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         shift_clk,
    input  wire logic         convert_strobe_n,
    input  wire logic         comparator_high,
    output logic [12:0]       capacitive_weighting_array_q,
    output logic              sampling_q,
    output logic              serial_data_q,
    output logic              serial_data_oe,
    output logic              word_valid_q,
    output sar_conversion_sequencer_pkg::result_word_t result_q,
    output logic              result_done_q
);

    // link-side reset and step toggle, both on shift-clock falls
    logic        link_rst_meta_q;
    logic        link_rst_q;
    logic        step_tgl_q;

    // system-side synchronised views
    logic        strobe_n_s;
    logic        strobe_n_prev_q;
    logic        tgl_s;
    logic        tgl_prev_q;
    logic        comp_s;
    logic        strobe_fall;
    logic        step_event;

    sar_conversion_sequencer_pkg::seq_state_t state_q;
    logic [3:0]  step_q;
    logic [12:0] mask_q;
    logic [12:0] trial_d;
    logic [12:0] shift_q;
    logic [12:0] capacitive_weighting_array_d;
    logic [12:0] mask_d;
    logic [3:0]  step_d;
    logic [12:0] shift_d;
    logic        serial_d;
    logic        conv_step;
    logic        result_load;

    // one approximation step: keep or drop the tested weight, try the next
    function automatic logic [12:0] sar_step(input logic [12:0] trial, input logic [12:0] mask,
                                             input logic keep);
        logic [12:0] kept;
        kept     = keep ? trial : (trial & ~mask);
        sar_step = kept | (mask >> 1);
    endfunction

    // the thirteenth step event closes the approximation
    function automatic logic final_step(input logic evt, input logic [3:0] step);
        final_step = evt && (step == `SCS_LAST_STEP);
    endfunction

    // offset binary to two's complement: only the msb flips, for every input style
    function automatic logic [12:0] to_twos(input logic [12:0] offset_code);
        to_twos = offset_code ^ `SCS_SIGN_FLIP;
    endfunction

    // reset for the link domain; needs link edges while rst is held
    always_ff @(negedge shift_clk)
    begin
        link_rst_meta_q <= rst;
        link_rst_q      <= link_rst_meta_q;
    end

    // every shift-clock fall inside a frame is one step event
    always_ff @(negedge shift_clk)
    begin
        if (link_rst_q)
            step_tgl_q <= 1'b0;
        else if (!convert_strobe_n)
            step_tgl_q <= ~step_tgl_q;
    end

    level_sync u_strobe_sync
    (
        .clk      (clk_sys),
        .async_in (convert_strobe_n),
        .sync_out (strobe_n_s)
    );

    level_sync u_step_sync
    (
        .clk      (clk_sys),
        .async_in (step_tgl_q),
        .sync_out (tgl_s)
    );

    level_sync u_comp_sync
    (
        .clk      (clk_sys),
        .async_in (comparator_high),
        .sync_out (comp_s)
    );

    // strobe history, taken from the second synchroniser stage only
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            strobe_n_prev_q <= 1'b1; // idle level, so reset leaves no false fall
        else
            strobe_n_prev_q <= strobe_n_s;
    end

    // step toggle history, also from the second stage
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            tgl_prev_q <= 1'b0;
        else
            tgl_prev_q <= tgl_s;
    end

    assign strobe_fall = strobe_n_prev_q & ~strobe_n_s;
    // steps only count while the strobe stays low
    assign step_event  = (tgl_s ^ tgl_prev_q) & ~strobe_n_s;
    assign trial_d     = sar_step(capacitive_weighting_array_q, mask_q, comp_s);

    // sampling phase while strobe high; a rising strobe aborts a conversion
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q    <= sar_conversion_sequencer_pkg::SEQ_SAMPLING;
            sampling_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                sar_conversion_sequencer_pkg::SEQ_SAMPLING:
                begin
                    if (strobe_fall)
                    begin
                        state_q    <= sar_conversion_sequencer_pkg::SEQ_CONVERTING;
                        sampling_q <= 1'b0;
                    end
                end
                sar_conversion_sequencer_pkg::SEQ_CONVERTING:
                begin
                    if (strobe_n_s || final_step(step_event, step_q))
                    begin
                        state_q    <= sar_conversion_sequencer_pkg::SEQ_SAMPLING;
                        sampling_q <= 1'b1;
                    end
                end
                default:
                begin
                    state_q    <= sar_conversion_sequencer_pkg::SEQ_SAMPLING;
                    sampling_q <= 1'b1;
                end
            endcase
        end
    end

    // an approximation step only counts inside a conversion
    assign conv_step   = (state_q == sar_conversion_sequencer_pkg::SEQ_CONVERTING) && step_event;

    // an aborted conversion never loads, the old result stays
    assign result_load = final_step(conv_step, step_q) && !strobe_n_s;

    // next trial code, tested weight and step count; offset binary inside,
    // so the comparator sees plain binary-weighted fractions
    always_comb
    begin
        capacitive_weighting_array_d = capacitive_weighting_array_q;
        mask_d                       = mask_q;
        step_d                       = step_q;
        if (strobe_fall)
        begin
            capacitive_weighting_array_d = `SCS_FIRST_TRIAL;
            mask_d                       = `SCS_FIRST_TRIAL;
            step_d                       = `SCS_STEP_RST;
        end
        else if (conv_step)
        begin
            capacitive_weighting_array_d = trial_d;
            mask_d                       = mask_q >> 1;
            step_d                       = step_q + 4'h1;
        end
    end

    // trial code to the weighting array
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            capacitive_weighting_array_q <= `SCS_FIRST_TRIAL;
        else
            capacitive_weighting_array_q <= capacitive_weighting_array_d;
    end

    // weight under test, one bit walking down
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            mask_q <= `SCS_FIRST_TRIAL;
        else
            mask_q <= mask_d;
    end

    // steps taken in this conversion
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            step_q <= `SCS_STEP_RST;
        else
            step_q <= step_d;
    end

    // result word: same coding for every input style, and nothing is
    // clamped; out-of-span inputs keep their codes for the receiver to judge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            result_q.code  <= `SCS_RESULT_RST;
            result_q.valid <= 1'b0;
        end
        else if (result_load)
        begin
            result_q.code  <= to_twos(trial_d);
            result_q.valid <= 1'b1;
        end
    end

    // one-cycle pulse beside each new result
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            result_done_q <= 1'b0;
        else
            result_done_q <= result_load;
    end

    // next output word and pin bit: strobe fall presents the previous msb at
    // once; steps past the twelfth shift zeros out
    always_comb
    begin
        shift_d  = shift_q;
        serial_d = serial_data_q;
        if (strobe_fall)
        begin
            shift_d  = result_q.code;
            serial_d = result_q.code[12];
        end
        else if (step_event)
        begin
            shift_d  = {shift_q[11:0], 1'b0};
            serial_d = shift_q[11];
        end
    end

    // output word under shift
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            shift_q <= `SCS_RESULT_RST;
        else
            shift_q <= shift_d;
    end

    // data pin bit
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            serial_data_q <= 1'b0;
        else
            serial_data_q <= serial_d;
    end

    // first word after reset belongs to no conversion
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            word_valid_q <= 1'b0;
        else if (strobe_fall)
            word_valid_q <= result_q.valid;
    end

    // data pin is driven only while the frame is open
    assign serial_data_oe = ~strobe_n_s;

endmodule // sar_conversion_sequencer

// File: verilog/sar_conversion_sequencer_consts.svh
// constants for the successive-approximation conversion sequencer
`ifndef SAR_CONVERSION_SEQUENCER_CONSTS_SVH
`define SAR_CONVERSION_SEQUENCER_CONSTS_SVH

`define SCS_WORD_BITS     13
`define SCS_STEP_COUNT    4'hD
`define SCS_LAST_STEP     4'hC
`define SCS_FIRST_TRIAL   13'h1000
`define SCS_SIGN_FLIP     13'h1000
`define SCS_RESULT_RST    13'h0000
`define SCS_STEP_RST      4'h0

`endif

// File: verilog/sar_conversion_sequencer_pkg.sv
// types shared by the conversion sequencer files
package sar_conversion_sequencer_pkg;

    typedef enum logic [0:0] {
        SEQ_SAMPLING,
        SEQ_CONVERTING
    } seq_state_t;

    typedef struct packed {
        logic [12:0] code;
        logic        valid;
    } result_word_t;

endpackage
